// *** dfp_pkg.sv ***
// Constants, register map and carrier types of the drive I/O force and parameter bank.
//
// Notes on behaviour
// - Force word holds 00 to 1F; bit 0 is output line 1, bit 4 line 5.
// - While forcing, a one bit drives its line active, a zero drives it inactive.
// - Active or inactive reaches the pin through that output's normally-closed setting.
// - Every change of the force word reaches the pins at once, with no confirm.
// - Leaving the force selection returns all outputs to their functional drive.
// - Forcing has no effect while the servo drive is enabled.
// - Input view lights one indicator per input line that is ON.
// - A disabled input line never lights its indicator.
// - A normally-closed input line reads ON when its contact is open.
// - Output view lights one indicator per output line that is active.
// - Parameters fall in five groups 0 to 4: monitor to diagnostic.
// - Writing 10 to the restore control returns parameters outside the monitor group, except the view selection, to factory defaults.
// - A mode change reloads I/O configuration only when the mode setting asks.
// - Locked parameters refuse writes while the drive is enabled.
// - Power-cycle parameters are stored now and applied after next power-up.
// - Volatile parameters are never saved and are lost at power-off.
// - The servo-on hour record is read-only, 0 to 65535, kept over a restore.
package dfp_pkg;
  localparam int          NUM_IN         = 8;
  localparam int          NUM_OUT        = 5;
  // ----------------------------------------------------------------
  // Register offsets; address bits 7:5 give the parameter group.
  // ----------------------------------------------------------------
  localparam logic [7:0]  OFS_HOURS      = 8'h00;
  localparam logic [7:0]  OFS_MONSEL     = 8'h04;
  localparam logic [7:0]  OFS_STATUS     = 8'h08;
  localparam logic [7:0]  OFS_MODE       = 8'h20;
  localparam logic [7:0]  OFS_RESTORE    = 8'h40;
  localparam logic [7:0]  OFS_IN_CFG     = 8'h44;
  localparam logic [7:0]  OFS_OUT_CFG    = 8'h48;
  localparam logic [7:0]  OFS_PCYC       = 8'h4C;
  localparam logic [7:0]  OFS_FORCE      = 8'h80;
  localparam logic [7:0]  OFS_VIEW       = 8'h84;
  localparam int          GRP_LSB        = 5;
  localparam logic [2:0]  GRP_LAST       = 3'h4;
  // ----------------------------------------------------------------
  // Field positions, values and reset values.
  // ----------------------------------------------------------------
  localparam int          MODE_RELOAD    = 4;
  localparam int          VIEW_FORCE     = 0;
  localparam int          VIEW_IN        = 1;
  localparam int          VIEW_OUT       = 2;
  localparam int          ST_OUT_LSB     = 8;
  localparam int          ST_SERVO       = 16;
  localparam int          PCYC_ACT_LSB   = 8;
  localparam logic [31:0] RESTORE_CODE   = 32'h0000000A;
  localparam logic [4:0]  FORCE_RST      = 5'h00;
  localparam logic [3:0]  MODE_RST       = 4'h0;
  localparam logic [15:0] IN_CFG_RST     = 16'h00FF;
  localparam logic [4:0]  OUT_NC_RST     = 5'h00;
  localparam logic [7:0]  PCYC_RST       = 8'h00;
  localparam logic [15:0] MONSEL_RST     = 16'h0000;
  localparam logic [15:0] HOURS_MAX      = 16'hFFFF;
  // ----------------------------------------------------------------
  // Timing: one servo-on hour at the 20 MHz bus clock.
  // ----------------------------------------------------------------
  localparam longint      HOUR_S         = 3600;
  localparam longint      CLK_HZ         = 20000000;
  localparam longint      HOUR_CYC       = HOUR_S * CLK_HZ;
  localparam int          HOUR_W         = 37;
  // ----------------------------------------------------------------
  // Types.
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    DFP_GRP_MONITOR = 3'h0,
    DFP_GRP_BASIC   = 3'h1,
    DFP_GRP_EXTEND  = 3'h2,
    DFP_GRP_COMM    = 3'h3,
    DFP_GRP_DIAG    = 3'h4
  } dfp_group_t;
  typedef struct packed {
    logic [15:0] hours;
    logic [15:0] monsel;
    logic [3:0]  mode;
    logic [15:0] in_cfg;
    logic [4:0]  out_nc;
    logic [7:0]  pcyc;
  } dfp_nv_t;
endpackage : dfp_pkg

// *** dfp_sync.sv ***
// Two-stage synchroniser for pin inputs.
`timescale 1ns/10ps
module dfp_sync #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule : dfp_sync

// *** dfp_tick.sv ***
// Enable-gated divider that pulses once every N counted cycles.
`timescale 1ns/10ps
module dfp_tick #(
  parameter int           W = 37,
  parameter logic [W-1:0] N = '1
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic en,
  output logic      tick
);
  logic [W-1:0] cnt_reg;
  wire          wrap = (cnt_reg == N - W'(1));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
      tick    <= 1'b0;
    end else begin
      tick <= en & wrap;
      if (en) begin
        cnt_reg <= wrap ? '0 : cnt_reg + W'(1);
      end
    end
  end
endmodule : dfp_tick

// *** dfp_top.sv ***
// APB parameter bank with output forcing, status display and hour record.
`timescale 1ns/10ps
module dfp_top #(
  parameter logic [36:0] HOUR_CYCLES = 37'(dfp_pkg::HOUR_CYC)
) (
  input  wire logic                           pclk,
  input  wire logic                           presetn,
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [7:0]                     paddr,
  input  wire logic [31:0]                    pwdata,
  output logic      [31:0]                    prdata,
  output logic                                pready,
  output logic                                pslverr,
  input  wire logic                           servo_enabled,
  input  wire logic [dfp_pkg::NUM_OUT-1:0]    func_out,
  input  wire logic [dfp_pkg::NUM_IN-1:0]     sensed_input_line,
  input  wire dfp_pkg::dfp_nv_t               nv_image,
  output dfp_pkg::dfp_nv_t                    nv_save,
  output logic      [dfp_pkg::NUM_OUT-1:0]    do_pin,
  output logic      [dfp_pkg::NUM_IN-1:0]     led,
  output logic      [7:0]                     pcyc_active
);
  // ----------------------------------------------------------------
  // State.
  // ----------------------------------------------------------------
  logic [4:0]  force_word_reg;
  logic [2:0]  view_reg;
  logic [3:0]  mode_reg;
  logic        reload_reg;
  logic [15:0] in_cfg_reg;
  logic [4:0]  out_nc_reg;
  logic [7:0]  pcyc_reg;
  logic [15:0] monsel_reg;
  logic [15:0] hours_reg;
  logic        boot_reg;
  logic [7:0]  in_s;
  logic        hour_tick;

  dfp_sync #(.W(dfp_pkg::NUM_IN)) u_in_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     (sensed_input_line),
    .q     (in_s)
  );

  dfp_tick #(.W(dfp_pkg::HOUR_W), .N(HOUR_CYCLES)) u_hour (
    .clk   (pclk),
    .rst_n (presetn),
    .en    (servo_enabled),
    .tick  (hour_tick)
  );

  // ----------------------------------------------------------------
  // Bus decode.
  // ----------------------------------------------------------------
  wire        setup     = psel & ~penable;
  wire        access    = psel & penable;
  wire [2:0]  grp       = paddr[7:dfp_pkg::GRP_LSB];
  wire        grp_ok    = (grp <= dfp_pkg::GRP_LAST);
  wire        hit_hours = (paddr == dfp_pkg::OFS_HOURS);
  wire        hit_mon   = (paddr == dfp_pkg::OFS_MONSEL);
  wire        hit_stat  = (paddr == dfp_pkg::OFS_STATUS);
  wire        hit_mode  = (paddr == dfp_pkg::OFS_MODE);
  wire        hit_rest  = (paddr == dfp_pkg::OFS_RESTORE);
  wire        hit_incfg = (paddr == dfp_pkg::OFS_IN_CFG);
  wire        hit_outc  = (paddr == dfp_pkg::OFS_OUT_CFG);
  wire        hit_pcyc  = (paddr == dfp_pkg::OFS_PCYC);
  wire        hit_force = (paddr == dfp_pkg::OFS_FORCE);
  wire        hit_view  = (paddr == dfp_pkg::OFS_VIEW);
  wire        hit_any   = grp_ok & (hit_hours | hit_mon | hit_stat | hit_mode | hit_rest
                          | hit_incfg | hit_outc | hit_pcyc | hit_force | hit_view);
  wire        hit_ro    = hit_hours | hit_stat;
  wire        hit_lock  = hit_mode | hit_incfg | hit_outc | hit_rest;
  wire        wr_err    = ~hit_any | hit_ro | (hit_lock & servo_enabled);
  wire        err       = pwrite ? wr_err : ~hit_any;
  wire        wr_ok     = access & pwrite & ~pslverr;

  // ----------------------------------------------------------------
  // Derived I/O levels.
  // ----------------------------------------------------------------
  wire [7:0]  in_on     = in_cfg_reg[7:0] & (in_s ^ in_cfg_reg[15:8]);
  wire        force_eff = view_reg[dfp_pkg::VIEW_FORCE] & ~servo_enabled;
  wire [4:0]  out_act   = force_eff ? force_word_reg : func_out;
  wire [4:0]  force_lvl = force_word_reg ^ out_nc_reg;
  wire [4:0]  func_lvl  = func_out ^ out_nc_reg;
  wire [4:0]  pin_next  = out_act ^ out_nc_reg;
  wire [7:0]  led_next  = view_reg[dfp_pkg::VIEW_IN]  ? in_on :
                          view_reg[dfp_pkg::VIEW_OUT] ? {3'h0, out_act} : 8'h00;

  // ----------------------------------------------------------------
  // Write effects.
  // ----------------------------------------------------------------
  wire        do_rest   = wr_ok & hit_rest & (pwdata == dfp_pkg::RESTORE_CODE);
  wire        mode_chg  = wr_ok & hit_mode & (pwdata[3:0] != mode_reg);
  wire        io_reload = do_rest | (mode_chg & pwdata[dfp_pkg::MODE_RELOAD]);
  wire [2:0]  view_next = pwdata[dfp_pkg::VIEW_IN]  ? 3'b010 :
                          pwdata[dfp_pkg::VIEW_OUT] ? 3'b100 :
                          {2'b00, pwdata[dfp_pkg::VIEW_FORCE]};
  wire [31:0] rd_next   = hit_hours ? {16'h0000, hours_reg} :
                          hit_mon   ? {16'h0000, monsel_reg} :
                          hit_stat  ? {15'h0000, servo_enabled, 3'h0, out_act, in_on} :
                          hit_mode  ? {27'h0000000, reload_reg, mode_reg} :
                          hit_incfg ? {16'h0000, in_cfg_reg} :
                          hit_outc  ? {27'h0000000, out_nc_reg} :
                          hit_pcyc  ? {16'h0000, pcyc_active, pcyc_reg} :
                          hit_force ? {27'h0000000, force_word_reg} :
                          hit_view  ? {29'h00000000, view_reg} : 32'h00000000;

  // ----------------------------------------------------------------
  // APB answer: one-cycle access, data prepared in the setup cycle.
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (setup) begin
        prdata  <= (pwrite | ~grp_ok) ? 32'h00000000 : rd_next;
        pslverr <= err;
      end
    end
  end

  // ----------------------------------------------------------------
  // Volatile diagnostic registers, cleared at power-up.
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      force_word_reg <= dfp_pkg::FORCE_RST;
      view_reg       <= 3'b000;
    end else begin
      if (do_rest) begin
        force_word_reg <= dfp_pkg::FORCE_RST;
      end else if (wr_ok & hit_force) begin
        force_word_reg <= pwdata[4:0];
      end
      if (wr_ok & hit_view) begin
        view_reg <= view_next;
      end
    end
  end

  // ----------------------------------------------------------------
  // Stored parameters, loaded from non-volatile image after power-up.
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_reg    <= 1'b1;
      mode_reg    <= dfp_pkg::MODE_RST;
      reload_reg  <= 1'b0;
      in_cfg_reg  <= dfp_pkg::IN_CFG_RST;
      out_nc_reg  <= dfp_pkg::OUT_NC_RST;
      pcyc_reg    <= dfp_pkg::PCYC_RST;
      pcyc_active <= dfp_pkg::PCYC_RST;
      monsel_reg  <= dfp_pkg::MONSEL_RST;
      hours_reg   <= 16'h0000;
    end else if (boot_reg) begin
      boot_reg    <= 1'b0;
      mode_reg    <= nv_image.mode;
      in_cfg_reg  <= nv_image.in_cfg;
      out_nc_reg  <= nv_image.out_nc;
      pcyc_reg    <= nv_image.pcyc;
      pcyc_active <= nv_image.pcyc;
      monsel_reg  <= nv_image.monsel;
      hours_reg   <= nv_image.hours;
    end else begin
      if (hour_tick & (hours_reg != dfp_pkg::HOURS_MAX)) begin
        hours_reg <= hours_reg + 16'h0001;
      end
      if (wr_ok & hit_mon) begin
        monsel_reg <= pwdata[15:0];
      end
      if (do_rest) begin
        mode_reg   <= dfp_pkg::MODE_RST;
        reload_reg <= 1'b0;
        pcyc_reg   <= dfp_pkg::PCYC_RST;
      end else begin
        if (wr_ok & hit_mode) begin
          mode_reg   <= pwdata[3:0];
          reload_reg <= pwdata[dfp_pkg::MODE_RELOAD];
        end
        if (wr_ok & hit_pcyc) begin
          pcyc_reg <= pwdata[7:0];
        end
      end
      if (io_reload) begin
        in_cfg_reg <= dfp_pkg::IN_CFG_RST;
        out_nc_reg <= dfp_pkg::OUT_NC_RST;
      end else begin
        if (wr_ok & hit_incfg) begin
          in_cfg_reg <= pwdata[15:0];
        end
        if (wr_ok & hit_outc) begin
          out_nc_reg <= pwdata[4:0];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Pins, display and save image.
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      do_pin  <= 5'h00;
      led     <= 8'h00;
      nv_save <= '0;
    end else begin
      do_pin  <= pin_next;
      led     <= led_next;
      nv_save <= '{hours: hours_reg, monsel: monsel_reg, mode: mode_reg,
                   in_cfg: in_cfg_reg, out_nc: out_nc_reg, pcyc: pcyc_reg};
    end
  end

  // ----------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_force_store;
    wr_ok & hit_force & ~do_rest |=> force_word_reg == $past(pwdata[4:0]);
  endproperty
  a_force_store: assert property (p_force_store) else $error("force word not stored");

  property p_force_pins;
    force_eff |=> do_pin == $past(force_lvl);
  endproperty
  a_force_pins: assert property (p_force_pins) else $error("forced pin level wrong");

  property p_force_now;
    wr_ok & hit_force & force_eff ##1 force_eff |=> do_pin == ($past(pwdata[4:0], 2) ^ $past(out_nc_reg));
  endproperty
  a_force_now: assert property (p_force_now) else $error("force change late");

  property p_unforced;
    ~view_reg[dfp_pkg::VIEW_FORCE] |=> do_pin == $past(func_lvl);
  endproperty
  a_unforced: assert property (p_unforced) else $error("outputs not functional");

  property p_enabled_blocks;
    servo_enabled |=> do_pin == $past(func_lvl);
  endproperty
  a_enabled_blocks: assert property (p_enabled_blocks) else $error("forced while enabled");

  property p_in_view;
    view_reg[dfp_pkg::VIEW_IN] |=> led == $past(in_on);
  endproperty
  a_in_view: assert property (p_in_view) else $error("input view wrong");

  property p_in_disabled;
    view_reg[dfp_pkg::VIEW_IN] & ~in_cfg_reg[0] |=> ~led[0];
  endproperty
  a_in_disabled: assert property (p_in_disabled) else $error("disabled input lit");

  property p_out_view;
    view_reg[dfp_pkg::VIEW_OUT] |=> led == {3'h0, $past(out_act)};
  endproperty
  a_out_view: assert property (p_out_view) else $error("output view wrong");

  property p_bad_group;
    setup & (grp > dfp_pkg::GRP_LAST) |=> pslverr;
  endproperty
  a_bad_group: assert property (p_bad_group) else $error("group above 4 accepted");

  property p_restore;
    do_rest |=> mode_reg == dfp_pkg::MODE_RST && in_cfg_reg == dfp_pkg::IN_CFG_RST;
  endproperty
  a_restore: assert property (p_restore) else $error("restore incomplete");

  property p_restore_keep;
    do_rest & ~hour_tick |=> $stable(hours_reg) && $stable(monsel_reg);
  endproperty
  a_restore_keep: assert property (p_restore_keep) else $error("restore cleared kept data");

  property p_mode_keep;
    mode_chg & ~pwdata[dfp_pkg::MODE_RELOAD] & ~do_rest |=> $stable(in_cfg_reg);
  endproperty
  a_mode_keep: assert property (p_mode_keep) else $error("io config reloaded");

  property p_locked;
    access & pwrite & hit_incfg & $past(servo_enabled) & ~boot_reg & ~io_reload |=> $stable(in_cfg_reg) && pready;
  endproperty
  a_locked: assert property (p_locked) else $error("locked write taken");

  property p_pcyc_late;
    ~boot_reg |=> $stable(pcyc_active);
  endproperty
  a_pcyc_late: assert property (p_pcyc_late) else $error("power-cycle value applied early");

  c_force: cover property (force_eff ##1 force_eff && do_pin != 5'h00);
  c_restore: cover property (do_rest);
  c_lock_refused: cover property (access & pwrite & hit_lock & servo_enabled);
  c_in_view: cover property (view_reg[dfp_pkg::VIEW_IN] && led != 8'h00);
endmodule : dfp_top

// *** dfp_io_model.sv ***
// Model of the external wiring and drive-side signals around the parameter bank.
`timescale 1ns/10ps
module dfp_io_model (
  input  wire logic       pclk,
  input  wire logic [7:0] contact_cmd,
  input  wire logic [4:0] func_cmd,
  input  wire logic       enable_cmd,
  output logic      [7:0] sensed_input_line,
  output logic      [4:0] func_out,
  output logic            servo_enabled
);
  // ----------------------------------------------------------------
  // Pin levels follow the commands one edge later.
  // ----------------------------------------------------------------
  initial begin
    sensed_input_line = 8'h00;
    func_out = 5'h00;
    servo_enabled = 1'b0;
  end
  always @(posedge pclk) begin
    sensed_input_line <= contact_cmd;
    func_out <= func_cmd;
    servo_enabled <= enable_cmd;
  end
endmodule : dfp_io_model

// *** dfp_top_test.sv ***
// Self-checking testbench of the force and parameter bank.
`timescale 1ns/10ps
module dfp_top_test;
  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [7:0]        paddr = 8'h00;
  logic [31:0]       pwdata = 32'h0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              servo_enabled;
  logic [4:0]        func_out;
  logic [7:0]        sensed_input_line;
  logic [7:0]        contact_cmd = 8'h00;
  logic [4:0]        func_cmd = 5'h00;
  logic              enable_cmd = 1'b0;
  dfp_pkg::dfp_nv_t  nv_image;
  dfp_pkg::dfp_nv_t  nv_save;
  dfp_pkg::dfp_nv_t  nv_tmp;
  logic [4:0]        do_pin;
  logic [7:0]        led;
  logic [7:0]        pcyc_active;
  logic [31:0]       rdv;
  logic              er;
  logic [15:0]       cfg;
  logic [4:0]        f;
  logic [4:0]        nc;
  logic [31:0]       h0;
  int                seed = 32'h96C38F2B;
  int                fails = 0;
  int                compares = 0;
  dfp_io_model u_io (.pclk(pclk), .contact_cmd(contact_cmd), .func_cmd(func_cmd), .enable_cmd(enable_cmd),
    .sensed_input_line(sensed_input_line), .func_out(func_out), .servo_enabled(servo_enabled));
  dfp_top #(.HOUR_CYCLES(37'h8)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .servo_enabled(servo_enabled), .func_out(func_out), .sensed_input_line(sensed_input_line),
    .nv_image(nv_image), .nv_save(nv_save), .do_pin(do_pin), .led(led), .pcyc_active(pcyc_active));
  // ----------------------------------------------------------------
  // Clock, checking and bus tasks.
  // ----------------------------------------------------------------
  initial begin
    forever #25 pclk = ~pclk;
  end
  task summarize;
    if (fails == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 20) begin
        fails++;
        summarize();
      end
      @(posedge pclk);
    end
    rdv = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
    apb(1'b1, a, d);
    chk({31'h0, er}, {31'h0, ee});
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] exp, input logic ee);
    apb(1'b0, a, 32'h0);
    chk(rdv, exp);
    chk({31'h0, er}, {31'h0, ee});
  endtask : rd
  task power_cycle(input logic [15:0] hrs);
    repeat (2) @(posedge pclk);
    nv_tmp = nv_save;
    nv_tmp.hours = hrs;
    nv_image <= nv_tmp;
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
  endtask : power_cycle
  function automatic logic [31:0] exp_led(input logic [7:0] pins, input logic [15:0] c);
    return {24'h0, c[7:0] & (pins ^ c[15:8])};
  endfunction : exp_led
  // ----------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------
  initial begin
    nv_image = '{hours: 16'h0003, monsel: 16'h0000, mode: 4'h0, in_cfg: 16'h00FF, out_nc: 5'h00, pcyc: 8'h33};
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(dfp_pkg::OFS_HOURS, 32'h3, 1'b0);
    rd(dfp_pkg::OFS_FORCE, 32'h0, 1'b0);
    rd(dfp_pkg::OFS_PCYC, 32'h3333, 1'b0);
    wr(dfp_pkg::OFS_HOURS, 32'h1234, 1'b1);
    rd(dfp_pkg::OFS_HOURS, 32'h3, 1'b0);
    rd(8'hA0, 32'h0, 1'b1);
    rd(8'hE4, 32'h0, 1'b1);
    nc = 5'($random(seed));
    func_cmd <= 5'($random(seed));
    wr(dfp_pkg::OFS_OUT_CFG, {27'h0, nc}, 1'b0);
    wr(dfp_pkg::OFS_VIEW, 32'h1, 1'b0);
    for (int i = 0; i < 12; i++) begin
      f = (i == 0) ? 5'h00 : (i == 1) ? 5'h1F : 5'($random(seed));
      wr(dfp_pkg::OFS_FORCE, {27'h0, f}, 1'b0);
      repeat (2) @(posedge pclk);
      chk({27'h0, do_pin}, {27'h0, f ^ nc});
      rd(dfp_pkg::OFS_FORCE, {27'h0, f}, 1'b0);
    end
    enable_cmd <= 1'b1;
    repeat (4) @(posedge pclk);
    chk({27'h0, do_pin}, {27'h0, func_out ^ nc});
    enable_cmd <= 1'b0;
    repeat (4) @(posedge pclk);
    chk({27'h0, do_pin}, {27'h0, f ^ nc});
    wr(dfp_pkg::OFS_VIEW, 32'h4, 1'b0);
    repeat (2) @(posedge pclk);
    chk({27'h0, do_pin}, {27'h0, func_out ^ nc});
    chk({24'h0, led}, {27'h0, func_out});
    wr(dfp_pkg::OFS_VIEW, 32'h2, 1'b0);
    for (int i = 0; i < 8; i++) begin
      cfg = (i == 0) ? 16'hFF00 : 16'($random(seed));
      contact_cmd <= (i == 0) ? 8'h00 : 8'($random(seed));
      wr(dfp_pkg::OFS_IN_CFG, {16'h0, cfg}, 1'b0);
      repeat (6) @(posedge pclk);
      chk({24'h0, led}, exp_led(contact_cmd, cfg));
    end
    rd(dfp_pkg::OFS_STATUS, {19'h0, func_out, 8'h0} | exp_led(contact_cmd, cfg), 1'b0);
    rd(dfp_pkg::OFS_VIEW, 32'h2, 1'b0);
    enable_cmd <= 1'b1;
    wr(dfp_pkg::OFS_IN_CFG, 32'h1234, 1'b1);
    wr(dfp_pkg::OFS_MODE, 32'h12, 1'b1);
    wr(dfp_pkg::OFS_RESTORE, 32'hA, 1'b1);
    rd(dfp_pkg::OFS_IN_CFG, {16'h0, cfg}, 1'b0);
    enable_cmd <= 1'b0;
    wr(dfp_pkg::OFS_MODE, 32'h12, 1'b0);
    rd(dfp_pkg::OFS_IN_CFG, 32'h00FF, 1'b0);
    wr(dfp_pkg::OFS_IN_CFG, 32'h0F0F, 1'b0);
    wr(dfp_pkg::OFS_MODE, 32'h3, 1'b0);
    rd(dfp_pkg::OFS_IN_CFG, 32'h0F0F, 1'b0);
    wr(dfp_pkg::OFS_FORCE, 32'h15, 1'b0);
    wr(dfp_pkg::OFS_MONSEL, 32'hBEEF, 1'b0);
    wr(dfp_pkg::OFS_PCYC, 32'h5A, 1'b0);
    chk({24'h0, pcyc_active}, 32'h33);
    power_cycle(16'h0003);
    rd(dfp_pkg::OFS_FORCE, 32'h0, 1'b0);
    rd(dfp_pkg::OFS_PCYC, 32'h5A5A, 1'b0);
    chk({24'h0, pcyc_active}, 32'h5A);
    wr(dfp_pkg::OFS_RESTORE, 32'hB, 1'b0);
    rd(dfp_pkg::OFS_IN_CFG, 32'h0F0F, 1'b0);
    wr(dfp_pkg::OFS_RESTORE, 32'hA, 1'b0);
    rd(dfp_pkg::OFS_IN_CFG, 32'h00FF, 1'b0);
    rd(dfp_pkg::OFS_MODE, 32'h0, 1'b0);
    rd(dfp_pkg::OFS_MONSEL, 32'hBEEF, 1'b0);
    rd(dfp_pkg::OFS_HOURS, 32'h3, 1'b0);
    h0 = 32'h3;
    enable_cmd <= 1'b1;
    repeat (80) @(posedge pclk);
    enable_cmd <= 1'b0;
    apb(1'b0, dfp_pkg::OFS_HOURS, 32'h0);
    chk({31'h0, (rdv - h0 >= 32'h9) && (rdv - h0 <= 32'hB)}, 32'h1);
    power_cycle(16'hFFFE);
    enable_cmd <= 1'b1;
    repeat (48) @(posedge pclk);
    enable_cmd <= 1'b0;
    rd(dfp_pkg::OFS_HOURS, 32'hFFFF, 1'b0);
    summarize();
  end
  initial begin
    repeat (100000) @(posedge pclk);
    fails++;
    summarize();
  end
endmodule : dfp_top_test
